/* core/hdpm_pkg.sv */
package hdpm_pkg;
  // ==========================================================
  // register offsets (device side, documented)
  localparam logic [7:0] AUX_CONTROL_OFS    = 8'h02;
  localparam logic [7:0] DMA_CONFIG_OFS     = 8'h14;
  localparam logic [7:0] DMA_TIMING_OFS     = 8'h16;
  localparam logic [7:0] HOST_CONFIG_OFS    = 8'h70;
  // ==========================================================
  // dma_config fields
  localparam int WORD_WIDE_BIT   = 6;
  localparam int ACK_HIGH_BIT    = 5;
  localparam int REQ_HIGH_BIT    = 4;
  localparam int MASTER_SEL_BIT  = 1;
  localparam int BURST_SEL_BIT   = 0;
  // dma_timing_control fields
  localparam int PORT_OE_BIT     = 7;
  localparam int STROBE_TIM_BIT  = 6;
  // aux_control fields
  localparam int CHAN_B_BIT      = 6;
  localparam int CHAN_A_BIT      = 5;
  localparam int STRIPE_BIT      = 4;
  localparam int MIRROR_BIT      = 0;
  // host_config_two field
  localparam int XFER_EN_BIT     = 7;
  // ==========================================================
  // reset values: word wide, master, strobe timing set, port off
  localparam logic [7:0] DMA_CONFIG_RST   = 8'h42;
  localparam logic [7:0] DMA_TIMING_RST   = 8'h40;
  localparam logic [7:0] AUX_CONTROL_RST  = 8'h00;
  // ==========================================================
  // controller (host side) axi-lite register map, own choice
  localparam logic [7:0] CTL_OFS          = 8'h00;
  localparam logic [7:0] STAT_OFS         = 8'h04;
  localparam logic [7:0] WDATA_OFS        = 8'h08;
  localparam logic [7:0] RDATA_OFS        = 8'h0c;
  localparam logic [7:0] CFG1_OFS         = 8'h10;
  // ctl register fields
  localparam int CTL_GO_BIT       = 0;
  localparam int CTL_DIR_BIT      = 1;
  localparam int CTL_ROLE_BIT     = 2;
  // strobe width in clock cycles, less one
  localparam logic [3:0] STROBE_CYC       = 4'h2;
  localparam logic [1:0] AXI_OKAY         = 2'h0;
  localparam logic [1:0] AXI_SLVERR       = 2'h2;
endpackage

/* core/hdpm_if.sv */
`timescale 1ns/10ps
// ==========================================================
// host dma port wires between scsi section and disk manager
interface hdpm_if;
  logic [15:0] hostBusDataDev;   // driven by scsi section
  logic        hostBusDataDevOe;
  logic [15:0] hostBusDataDsk;   // driven by disk manager
  logic        hostBusDataDskOe;
  logic        parityHighDev;
  logic        parityLowDev;
  logic        parityHighDsk;
  logic        parityLowDsk;
  logic        requestA;
  logic        requestB;
  logic        acknowledgeA;
  logic        acknowledgeB;
  logic        ackOe;
  logic        writeStrobeN;
  logic        readStrobeN;
  logic        strobeOe;
  logic        testInputHi;
  logic        testInputLo;
  modport scsi
  (
    output hostBusDataDev, hostBusDataDevOe, parityHighDev, parityLowDev,
    input  hostBusDataDsk, hostBusDataDskOe, parityHighDsk, parityLowDsk,
    input  requestA, requestB,
    output acknowledgeA, acknowledgeB, ackOe,
    output writeStrobeN, readStrobeN, strobeOe,
    input  testInputHi, testInputLo
  );
  modport disk
  (
    input  hostBusDataDev, hostBusDataDevOe, parityHighDev, parityLowDev,
    output hostBusDataDsk, hostBusDataDskOe, parityHighDsk, parityLowDsk,
    output requestA, requestB,
    input  acknowledgeA, acknowledgeB, ackOe,
    input  writeStrobeN, readStrobeN, strobeOe,
    output testInputHi, testInputLo
  );
endinterface

/* core/hdpm_sync.sv */
`timescale 1ns/10ps
// ==========================================================
// two flip-flop synchroniser for pin levels
module hdpm_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  initial
  begin
    if (WIDTH < 1)
      $error("hdpm_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule

/* core/hdpm_scsi_port.sv */
`timescale 1ns/10ps
// Summary of operation
// (RULE1) one shared dma port for all three sections
// (RULE2) sixteen data lines plus two byte parities
// (RULE3) normal mode: scsi master, disk managers slaves
// (RULE4) master drives both acknowledges and strobes
// (RULE5) slaves drive both request lines
// (RULE6) mirror: internal disk master, single cycle
// (RULE7) word wide select bit six set
// (RULE8) acknowledge level matches disk config bit five
// (RULE9) request level matches disk config bit four
// (RULE10) master select bit one set
// (RULE11) burst bit matches disk burst bit
// (RULE12) strobe timing set; output enable normal only
// (RULE13) channel a select for internal transfers
// (RULE14) channel b select for normal or striping
// (RULE15) striping enable only when striping needed
// (RULE16) mirror bit zero for normal transfers
// (RULE17) mirror: both channels, no stripe, mirror set; the mirrorMode decode ignores the mirror bit
// (RULE18) normal: disk master select bit zero
// (RULE19) mirror: internal master, external slave, nonburst
// (RULE20) disk transfer enable set before transfers
// (RULE21) both test inputs held high
// (RULE22) channel a internal, channel b external
// (RULE23) mirror write moves only when both requests
module hdpm_scsi_port
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  hdpm_if.scsi             port,
  // register access
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  // word stream
  input  wire logic        xferGo,
  input  wire logic        xferWrite,
  input  wire logic [15:0] xferWdata,
  output logic      [15:0] xferRdata,
  output logic             xferDone,
  output logic             xferBusy,
  output logic             parityError
);
  // ==========================================================
  // configuration registers
  logic [7:0] dmaConfig_reg;
  logic [7:0] dmaTiming_reg;
  logic [7:0] auxControl_reg;
  wire  wrCfg = regWrite && (regAddr == hdpm_pkg::DMA_CONFIG_OFS);
  wire  wrTim = regWrite && (regAddr == hdpm_pkg::DMA_TIMING_OFS);
  wire  wrAux = regWrite && (regAddr == hdpm_pkg::AUX_CONTROL_OFS);

  // word wide and master bits are forced, software cannot clear them
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dmaConfig_reg  <= hdpm_pkg::DMA_CONFIG_RST;
      dmaTiming_reg  <= hdpm_pkg::DMA_TIMING_RST;
      auxControl_reg <= hdpm_pkg::AUX_CONTROL_RST;
    end
    else
    begin
      if (wrCfg)
        dmaConfig_reg <= regWdata | hdpm_pkg::DMA_CONFIG_RST; // RULE7 RULE10
      if (wrTim)
        dmaTiming_reg <= regWdata | hdpm_pkg::DMA_TIMING_RST; // RULE12
      if (wrAux)
        auxControl_reg <= regWdata;
    end
  end

  // read mux, unmapped reads zero
  assign regRdata =
    (regAddr == hdpm_pkg::DMA_CONFIG_OFS)  ? dmaConfig_reg  :
    (regAddr == hdpm_pkg::DMA_TIMING_OFS)  ? dmaTiming_reg  :
    (regAddr == hdpm_pkg::AUX_CONTROL_OFS) ? auxControl_reg : 8'h00;

  // ==========================================================
  // decoded mode bits
  wire ackActiveHigh  = dmaConfig_reg[hdpm_pkg::ACK_HIGH_BIT];   // RULE8
  wire reqActiveHigh  = dmaConfig_reg[hdpm_pkg::REQ_HIGH_BIT];   // RULE9
  wire burstSel       = dmaConfig_reg[hdpm_pkg::BURST_SEL_BIT];  // RULE11
  wire portOutEnable  = dmaTiming_reg[hdpm_pkg::PORT_OE_BIT];
  wire chanBSelect    = auxControl_reg[hdpm_pkg::CHAN_B_BIT];
  wire chanASelect    = auxControl_reg[hdpm_pkg::CHAN_A_BIT];
  wire stripingEnable = auxControl_reg[hdpm_pkg::STRIPE_BIT];
  wire mirrorSel      = auxControl_reg[hdpm_pkg::MIRROR_BIT];
  // master only in normal mode with port enabled
  wire normalMode = portOutEnable && !mirrorSel;     // RULE12 RULE16
  wire mirrorMode = chanASelect && chanBSelect
                    && !stripingEnable;              // RULE17 RULE15

  // ==========================================================
  // pin synchronisers
  logic [1:0] reqSync;
  logic [17:0] busSync;
  logic [1:0] tstSync;
  hdpm_sync #(.WIDTH(2)) uReqSync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .pinIn   ({port.requestB, port.requestA}),
    .syncOut (reqSync)
  );
  hdpm_sync #(.WIDTH(18)) uBusSync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .pinIn   ({port.parityHighDsk, port.parityLowDsk, port.hostBusDataDsk}),
    .syncOut (busSync)
  );
  hdpm_sync #(.WIDTH(2)) uTstSync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .pinIn   ({port.testInputHi, port.testInputLo}),
    .syncOut (tstSync)
  );

  // request levels turned into active-true form
  wire reqA = (reqSync[0] == reqActiveHigh);                    // RULE9
  wire reqB = (reqSync[1] == reqActiveHigh);
  wire pinsOk = &tstSync;                                       // RULE21
  // channel a faces the internal manager, channel b the external one
  wire useA = chanASelect;                               // RULE22 RULE13
  wire useB = chanBSelect;                                      // RULE14
  // mirror write needs both requests; otherwise any selected channel
  wire reqReady = (mirrorMode && xferWrite) ? (reqA && reqB)    // RULE23
                : ((useA && reqA) || (useB && reqB));

  // ==========================================================
  // transfer state machine
  typedef enum logic [3:0]
  {
    IDLE   = 4'b0001,
    WAITRQ = 4'b0010,
    STROBE = 4'b0100,
    RELEAS = 4'b1000
  } hdpm_state_t;
  hdpm_state_t state_reg;
  hdpm_state_t state_next;
  logic [3:0]  cnt_reg;
  logic        ackA_reg;
  logic        ackB_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic        perr_reg;
  logic        done_reg;
  logic        stall;

  assign stall = !reqReady && !burstSel;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE:   if (xferGo && normalMode && pinsOk) state_next = WAITRQ; // RULE3
      WAITRQ: if (reqReady) state_next = STROBE;                   // RULE5
      STROBE: if (cnt_reg == hdpm_pkg::STROBE_CYC) state_next = RELEAS;
      RELEAS: state_next = IDLE;                    // single cycle RULE6
      default: state_next = IDLE;
    endcase
  end

  // one word per handshake; acknowledge drops after every word, burst bit or not
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= IDLE;
      cnt_reg   <= 4'h0;
      ackA_reg  <= 1'b0;
      ackB_reg  <= 1'b0;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      perr_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      done_reg  <= (state_reg == RELEAS);
      cnt_reg   <= (state_reg == STROBE) ? cnt_reg + 4'h1 : 4'h0;
      if (state_reg == IDLE && xferGo)
        wdata_reg <= xferWdata;
      ackA_reg <= (state_next == STROBE) && useA;               // RULE4
      ackB_reg <= (state_next == STROBE) && useB;
      if (state_reg == STROBE && cnt_reg == hdpm_pkg::STROBE_CYC
          && !xferWrite)
      begin
        rdata_reg <= busSync[15:0];
        perr_reg  <= (busSync[17] != ~^busSync[15:8])            // RULE2
                  || (busSync[16] != ~^busSync[7:0]);
      end
    end
  end

  // ==========================================================
  // pin drive; acknowledge polarity per config
  wire strobing = (state_reg == STROBE);
  assign port.acknowledgeA   = ackA_reg ~^ ackActiveHigh;        // RULE8
  assign port.acknowledgeB   = ackB_reg ~^ ackActiveHigh;
  assign port.ackOe          = normalMode;                       // RULE4
  assign port.strobeOe       = normalMode;
  assign port.writeStrobeN   = !(strobing && xferWrite);
  assign port.readStrobeN    = !(strobing && !xferWrite);
  assign port.hostBusDataDev = wdata_reg;                        // RULE1
  assign port.hostBusDataDevOe = normalMode && xferWrite && strobing;
  assign port.parityHighDev  = ~^wdata_reg[15:8];                // RULE2
  assign port.parityLowDev   = ~^wdata_reg[7:0];
  assign xferRdata           = rdata_reg;
  assign xferDone            = done_reg;
  assign xferBusy            = (state_reg != IDLE) || stall && 1'b0;
  assign parityError         = perr_reg;
endmodule

/* core/hdpm_disk_ctrl.sv */
`timescale 1ns/10ps
// ==========================================================
// disk manager end, controlled over axi4-lite
module hdpm_disk_ctrl
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  hdpm_if.disk             port,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  // ==========================================================
  // own registers
  logic [7:0]  cfg1_reg;     // ack/req level, master select, burst
  logic [7:0]  cfg2_reg;     // transfer enable
  logic [15:0] wword_reg;
  logic [15:0] rword_reg;
  logic        pending_reg;
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic        wStrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready  = !wHeld_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  wire doWrite   = awHeld_reg && wHeld_reg && !bvalid_reg;
  wire wrCfg1    = doWrite && awAddr_reg == hdpm_pkg::CFG1_OFS && wStrb0_reg;
  wire wrCtl     = doWrite && awAddr_reg == hdpm_pkg::CTL_OFS && wStrb0_reg;
  wire wrWord    = doWrite && awAddr_reg == hdpm_pkg::WDATA_OFS;
  wire wrOk      = awAddr_reg == hdpm_pkg::CFG1_OFS
                || awAddr_reg == hdpm_pkg::CTL_OFS
                || awAddr_reg == hdpm_pkg::WDATA_OFS;

  // ==========================================================
  // pin side: strobes seen only after two flops
  logic [3:0] pinSync;
  hdpm_sync #(.WIDTH(4)) uPinSync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .pinIn   ({port.acknowledgeA, port.acknowledgeB,
               port.writeStrobeN, port.readStrobeN}),
    .syncOut (pinSync)
  );
  logic [15:0] dataSync;
  hdpm_sync #(.WIDTH(16)) uDataSync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .pinIn   (port.hostBusDataDev),
    .syncOut (dataSync)
  );
  wire ackLvl  = cfg1_reg[hdpm_pkg::ACK_HIGH_BIT];
  wire reqLvl  = cfg1_reg[hdpm_pkg::REQ_HIGH_BIT];
  wire ackSeen = (pinSync[3] == ackLvl) || (pinSync[2] == ackLvl);
  wire wrEdge  = ackSeen && !pinSync[1];
  wire rdEdge  = ackSeen && !pinSync[0];
  // slave unless master select set; enable gates any request
  wire slave   = !cfg1_reg[hdpm_pkg::MASTER_SEL_BIT];            // RULE18
  wire enabled = cfg2_reg[hdpm_pkg::XFER_EN_BIT];                // RULE20
  wire reqOn   = pending_reg && enabled && slave && !ackSeen;    // RULE5

  // ==========================================================
  // register and transfer state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg1_reg <= 8'h00;
      cfg2_reg <= 8'h00;
      wword_reg <= 16'h0000;
      rword_reg <= 16'h0000;
      pending_reg <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= hdpm_pkg::AXI_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= hdpm_pkg::AXI_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_reg  <= 1'b1;
        wData_reg  <= wdata;
        wStrb0_reg <= wstrb[0];
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wrOk ? hdpm_pkg::AXI_OKAY : hdpm_pkg::AXI_SLVERR;
      end
      else if (bvalid_reg && bready)
        bvalid_reg <= 1'b0;
      if (wrCfg1)
        cfg1_reg <= wData_reg[7:0];                       // RULE8 RULE9 RULE11
      if (wrCtl)
        cfg2_reg <= wData_reg[7:0];
      if (wrWord)
        wword_reg <= wData_reg[15:0];
      // one word pending until the master strobes it; set wins
      if (wrWord || (wrCtl && wData_reg[hdpm_pkg::CTL_GO_BIT]))
        pending_reg <= 1'b1;
      else if (wrEdge || rdEdge)
        pending_reg <= 1'b0;
      if (wrEdge)
        rword_reg <= dataSync;
      if (arvalid && arready)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= hdpm_pkg::AXI_OKAY;
        unique case (araddr)
          hdpm_pkg::CFG1_OFS:  rdata_reg <= {24'h000000, cfg1_reg};
          hdpm_pkg::CTL_OFS:   rdata_reg <= {24'h000000, cfg2_reg};
          hdpm_pkg::STAT_OFS:  rdata_reg <= {31'h00000000, pending_reg};
          hdpm_pkg::RDATA_OFS: rdata_reg <= {16'h0000, rword_reg};
          default:
          begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= hdpm_pkg::AXI_SLVERR;
          end
        endcase
      end
      else if (rvalid_reg && rready)
        rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive: both request lines carry the same pending word
  assign port.requestA        = reqOn ~^ reqLvl;                 // RULE22
  assign port.requestB        = reqOn ~^ reqLvl;
  assign port.hostBusDataDsk  = wword_reg;
  assign port.hostBusDataDskOe = rdEdge;
  assign port.parityHighDsk   = ~^wword_reg[15:8];               // RULE2
  assign port.parityLowDsk    = ~^wword_reg[7:0];
  assign port.testInputHi     = 1'b1;                            // RULE21
  assign port.testInputLo     = 1'b1;
  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata  = rdata_reg;
  assign rresp  = rresp_reg;
endmodule

/* sim/hdpm_dma_sva.sv */
`timescale 1ns/10ps
// ==========================================================
// wire checks on the port between scsi section and disk manager
module hdpm_dma_sva
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] hostBusDataDev,
  input wire logic        hostBusDataDevOe,
  input wire logic [15:0] hostBusDataDsk,
  input wire logic        hostBusDataDskOe,
  input wire logic        parityHighDev,
  input wire logic        parityLowDev,
  input wire logic        parityHighDsk,
  input wire logic        parityLowDsk,
  input wire logic        ackOe,
  input wire logic        writeStrobeN,
  input wire logic        readStrobeN,
  input wire logic        strobeOe,
  input wire logic        testInputHi,
  input wire logic        testInputLo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // strobes stand low for STROBE_CYC plus one cycles, three in all
  sequence s_wr_low;
    !writeStrobeN [*3];
  endsequence
  sequence s_rd_low;
    !readStrobeN [*3];
  endsequence

  // two drivers on the shared data lines would fight
  property p_one_driver;
    !(hostBusDataDevOe && hostBusDataDskOe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the data lines");

  // odd parity per byte from either end
  property p_dev_parity;
    hostBusDataDevOe |-> parityHighDev == ~^hostBusDataDev[15:8]
      && parityLowDev == ~^hostBusDataDev[7:0];
  endproperty
  a_dev_parity: assert property (p_dev_parity)
    else $error("scsi parity wrong");
  property p_dsk_parity;
    hostBusDataDskOe |-> parityHighDsk == ~^hostBusDataDsk[15:8]
      && parityLowDsk == ~^hostBusDataDsk[7:0];
  endproperty
  a_dsk_parity: assert property (p_dsk_parity)
    else $error("disk parity wrong");

  property p_wr_width;
    $fell(writeStrobeN) |-> s_wr_low ##1 writeStrobeN;
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe width wrong");
  property p_rd_width;
    $fell(readStrobeN) |-> s_rd_low ##1 readStrobeN;
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("read strobe width wrong");

  // write data is held while the slave may sample it
  property p_wr_data;
    $fell(writeStrobeN) |-> hostBusDataDevOe ##1 $stable(hostBusDataDev) [*2];
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not held");

  // the slave answers a read strobe through its synchroniser
  property p_rd_answer;
    $fell(readStrobeN) |-> ##[0:4] hostBusDataDskOe;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("disk did not drive read data");

  property p_no_both;
    !(!writeStrobeN && !readStrobeN);
  endproperty
  a_no_both: assert property (p_no_both)
    else $error("both strobes active");

  property p_oe_pair;
    ackOe == strobeOe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("acknowledge and strobe enables differ");

  property p_test_pins;
    testInputHi && testInputLo;
  endproperty
  a_test_pins: assert property (p_test_pins)
    else $error("test inputs not high");
endmodule

/* sim/test_host_dma_port_mode_config.sv */
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
// ==========================================================
// bench: scsi end and disk end joined by the interface
module test_host_dma_port_mode_config;
  logic        clk;
  logic        rst_b;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic [7:0]  regRdata;
  logic        xferGo;
  logic        xferWrite;
  logic [15:0] xferWdata;
  logic [15:0] xferRdata;
  logic        xferDone;
  logic        xferBusy;
  logic        parityError;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [31:0] rd;
  logic [1:0]  rr;
  bit          seen;
  int          mismatches;
  int          check_count;

  hdpm_if bus();
  hdpm_scsi_port u_hdpm_scsi_port (.clk(clk), .rst_b(rst_b), .port(bus),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .xferGo(xferGo),
    .xferWrite(xferWrite), .xferWdata(xferWdata), .xferRdata(xferRdata),
    .xferDone(xferDone), .xferBusy(xferBusy), .parityError(parityError));
  hdpm_disk_ctrl u_hdpm_disk_ctrl (.clk(clk), .rst_b(rst_b), .port(bus),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  hdpm_dma_sva u_hdpm_dma_sva (.clk(clk), .rst_b(rst_b),
    .hostBusDataDev(bus.hostBusDataDev),
    .hostBusDataDevOe(bus.hostBusDataDevOe),
    .hostBusDataDsk(bus.hostBusDataDsk),
    .hostBusDataDskOe(bus.hostBusDataDskOe),
    .parityHighDev(bus.parityHighDev), .parityLowDev(bus.parityLowDev),
    .parityHighDsk(bus.parityHighDsk), .parityLowDsk(bus.parityLowDsk),
    .ackOe(bus.ackOe), .writeStrobeN(bus.writeStrobeN),
    .readStrobeN(bus.readStrobeN), .strobeOe(bus.strobeOe),
    .testInputHi(bus.testInputHi), .testInputLo(bus.testInputLo));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // ==========================================================
  // verdict and bounded-wait exit
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang;
    mismatches++;
    end_sim;
  endtask

  // ==========================================================
  // bus tasks
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic dev_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      done = (bvalid === 1'b1);
    end
    bready <= 1'b0;
    if (!done) hang();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      done = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
    end
    rready <= 1'b0;
    if (!done) hang();
  endtask
  task automatic word(input logic w, input logic [15:0] d, input int lim);
    @(posedge clk);
    xferGo <= 1'b1;
    xferWrite <= w;
    xferWdata <= d;
    @(posedge clk);
    xferGo <= 1'b0;
    seen = 0;
    for (int n = 0; n < lim && !seen; n++)
    begin
      @(posedge clk);
      seen = (xferDone === 1'b1);
    end
  endtask

  // ==========================================================
  // scenarios
  // forced bits survive a write of zero; level and burst bits follow
  task automatic t_dev_regs;
    dev_chk(hdpm_pkg::DMA_CONFIG_OFS, 8'h42);
    dev_chk(hdpm_pkg::DMA_TIMING_OFS, 8'h40);
    dev_chk(hdpm_pkg::AUX_CONTROL_OFS, 8'h00);
    dev_wr(hdpm_pkg::DMA_CONFIG_OFS, 8'h00);
    dev_chk(hdpm_pkg::DMA_CONFIG_OFS, 8'h42);
    dev_wr(hdpm_pkg::DMA_CONFIG_OFS, 8'h31);
    dev_chk(hdpm_pkg::DMA_CONFIG_OFS, 8'h73);
    dev_wr(hdpm_pkg::AUX_CONTROL_OFS, 8'h61);
    dev_chk(hdpm_pkg::AUX_CONTROL_OFS, 8'h61);
    dev_wr(hdpm_pkg::AUX_CONTROL_OFS, 8'h70);
    dev_chk(hdpm_pkg::AUX_CONTROL_OFS, 8'h70);
    dev_chk(8'h20, 8'h00);
  endtask
  task automatic t_axi_regs;
    axi_rd(hdpm_pkg::CFG1_OFS, rd, rr);
    `CHK(rd, 32'h0)
    axi_wr(hdpm_pkg::CFG1_OFS, 32'h30);
    axi_rd(hdpm_pkg::CFG1_OFS, rd, rr);
    `CHK(rd, 32'h30)
    axi_rd(8'h40, rd, rr);
    `CHK({rr, rd}, {hdpm_pkg::AXI_SLVERR, 32'h0})
  endtask
  // normal mode: ack and request high, single cycle, both channels
  task automatic t_normal;
    dev_wr(hdpm_pkg::DMA_CONFIG_OFS, 8'h72);
    dev_wr(hdpm_pkg::DMA_TIMING_OFS, 8'hc0);
    dev_wr(hdpm_pkg::AUX_CONTROL_OFS, 8'h60);
    dev_chk(hdpm_pkg::DMA_TIMING_OFS, 8'hc0);
    // disk not enabled: the word must wait
    axi_wr(hdpm_pkg::CTL_OFS, 32'h03);
    word(1'b1, 16'ha5c3, 60);
    `CHK({seen, xferBusy}, 2'b01)
    axi_wr(hdpm_pkg::CTL_OFS, 32'h83);
    seen = 0;
    for (int n = 0; n < 200 && !seen; n++)
    begin
      @(posedge clk);
      seen = (xferDone === 1'b1);
    end
    `CHK(seen, 1'b1)
    axi_rd(hdpm_pkg::RDATA_OFS, rd, rr);
    `CHK(rd, 32'h0000a5c3)
    // disk to scsi with an even bit count in the high byte, odd in the low
    axi_wr(hdpm_pkg::WDATA_OFS, 32'h5a3d);
    axi_wr(hdpm_pkg::CTL_OFS, 32'h81);
    word(1'b0, 16'h0000, 200);
    `CHK(seen, 1'b1)
    `CHK({xferRdata, parityError}, {16'h5a3d, 1'b0})
  endtask

  initial
  begin
    clk = 0;
    rst_b = 0;
    regWrite = 0;
    regRead = 0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    xferGo = 0;
    xferWrite = 0;
    xferWdata = 16'h0000;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_dev_regs();
    t_axi_regs();
    t_normal();
    end_sim();
  end
endmodule
